// [logic/bstap_top.sv]
// boundary-scan tap controller with instruction decode
`timescale 1ns/1ns
`default_nettype none
`include "bstap_map.svh"
module bstap_top
  import bstap_pkg::*;
#(
  parameter logic [31:0] ID_VALUE = 32'h0000_0001, // arbitrary value
  parameter logic [31:0] USER_VALUE = 32'hFFFF_FFFF
)(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // test link pins
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  // boundary-scan register serial path
  input wire logic bsr_so_i,
  output logic bsr_si_o,
  output logic bsr_shift_o,
  output logic bsr_capture_o,
  output logic bsr_update_o,
  // io shift register serial path
  input wire logic io_config_shift_reg_so_i,
  output logic io_config_shift_reg_sel_o,
  // pin control
  input wire logic hold_feature_i,
  output logic pins_float_o,
  output logic pins_clamp_o,
  output logic pins_extest_o,
  output logic scan_active_o,
  // configuration control
  output logic config_request_n_o,
  output logic cfg_ctrl_idle_o,
  output logic [21:0] flash_boot_addr_o,
  output logic flash_boot_load_o
);
  // two flops on each of tck, tms and tdi before use
  logic [1:0] tck_s_q, tms_s_q, tdi_s_q;
  logic tck_d1_q;
  always_ff @(posedge clk_sys_i)
  begin
    tck_s_q <= {tck_s_q[0], tck_i};
    tms_s_q <= {tms_s_q[0], tms_i};
    tdi_s_q <= {tdi_s_q[0], tdi_i};
    tck_d1_q <= tck_s_q[1];
  end
  wire tck_rise = tck_s_q[1] & ~tck_d1_q;
  wire tck_fall = ~tck_s_q[1] & tck_d1_q;
  wire tms = tms_s_q[1];
  wire tdi = tdi_s_q[1];

  bstap_state_e st_q, st_d;
  always_comb
  begin
    unique case (st_q)
      ST_RESET: st_d = tms ? ST_RESET : ST_IDLE;
      ST_IDLE: st_d = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: st_d = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: st_d = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: st_d = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: st_d = tms ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: st_d = tms ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: st_d = tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: st_d = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: st_d = tms ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: st_d = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: st_d = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: st_d = tms ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: st_d = tms ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: st_d = tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: st_d = tms ? ST_SEL_DR : ST_IDLE;
    endcase
  end
  // srst_i stands in for power-up; no tck edge needed to get to reset
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      st_q <= ST_RESET;
    else if (tck_rise)
      st_q <= st_d;
  end

  // instruction path
  logic [9:0] ir_sh_q, ir_q;
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i || (tck_rise && st_q == ST_RESET))
      ir_q <= `BSTAP_IR_IDCODE;
    else if (tck_rise && st_q == ST_UPD_IR)
      ir_q <= ir_sh_q;
  end
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      ir_sh_q <= `BSTAP_IR_CAPTURE;
    else if (tck_rise && st_q == ST_CAP_IR)
      ir_sh_q <= `BSTAP_IR_CAPTURE;
    else if (tck_rise && st_q == ST_SH_IR)
      ir_sh_q <= {tdi, ir_sh_q[9:1]};
  end

  // decode
  wire is_bsr = (ir_q == `BSTAP_IR_SAMPLE) || (ir_q == `BSTAP_IR_EXTEST);
  wire is_id = ir_q == `BSTAP_IR_IDCODE;
  wire is_user = ir_q == `BSTAP_IR_USERCODE;
  wire is_boot = ir_q == `BSTAP_IR_BOOT_ADDR;
  wire is_cfgio = ir_q == `BSTAP_IR_CONFIG_IO;
  bstap_dr_e dr_sel;
  assign dr_sel = is_bsr ? DR_BSR : is_id ? DR_IDCODE : is_user ? DR_USERCODE
                : is_boot ? DR_BOOT : DR_BYPASS;

  // data registers; id and user share one 32-bit shifter
  logic [31:0] dr32_q;
  logic [21:0] boot_sh_q;
  logic byp_q;
  wire cap_dr = tck_rise && st_q == ST_CAP_DR;
  wire sh_dr = tck_rise && st_q == ST_SH_DR;
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      dr32_q <= 32'h0;
    else if (cap_dr)
      dr32_q <= is_user ? USER_VALUE : ID_VALUE;
    else if (sh_dr)
      dr32_q <= {tdi, dr32_q[31:1]};
  end
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      byp_q <= 1'b0;
    else if (cap_dr)
      byp_q <= 1'b0;
    else if (sh_dr)
      byp_q <= tdi;
  end
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      boot_sh_q <= 22'h0;
    else if (sh_dr && dr_sel == DR_BOOT)
      boot_sh_q <= {tdi, boot_sh_q[21:1]};
  end
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      flash_boot_addr_o <= 22'h0;
      flash_boot_load_o <= 1'b0;
    end
    else
    begin
      flash_boot_load_o <= tck_rise && st_q == ST_UPD_DR && is_boot;
      if (tck_rise && st_q == ST_UPD_DR && is_boot)
        flash_boot_addr_o <= boot_sh_q;
    end
  end

  // serial out mux
  logic dr_bit;
  always_comb
  begin
    unique case (dr_sel)
      DR_BSR: dr_bit = bsr_so_i;
      DR_IDCODE, DR_USERCODE: dr_bit = dr32_q[0];
      DR_BOOT: dr_bit = boot_sh_q[0];
      default: dr_bit = is_cfgio ? io_config_shift_reg_so_i : byp_q;
    endcase
  end
  wire in_ir = st_q == ST_SH_IR;
  wire in_shift = in_ir || st_q == ST_SH_DR;
  // tdo follows the state only at falling tck, like the real pin
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      tdo_o <= 1'b0;
      tdo_oe_o <= 1'b0;
    end
    else if (tck_fall)
    begin
      tdo_oe_o <= in_shift;
      tdo_o <= in_ir ? ir_sh_q[0] : dr_bit;
    end
  end

  // pin and configuration controls
  logic rcfg_q;
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      pins_float_o <= 1'b0;
      pins_clamp_o <= 1'b0;
      pins_extest_o <= 1'b0;
      scan_active_o <= 1'b0;
      cfg_ctrl_idle_o <= 1'b0;
      config_request_n_o <= 1'b1;
      rcfg_q <= 1'b0;
      bsr_si_o <= 1'b0;
      bsr_shift_o <= 1'b0;
      bsr_capture_o <= 1'b0;
      bsr_update_o <= 1'b0;
      io_config_shift_reg_sel_o <= 1'b0;
    end
    else
    begin
      // bus hold and pull-up keep the pin, so float is masked
      pins_float_o <= (ir_q == `BSTAP_IR_HIGHZ) && !hold_feature_i;
      pins_clamp_o <= ir_q == `BSTAP_IR_CLAMP;
      pins_extest_o <= ir_q == `BSTAP_IR_EXTEST;
      scan_active_o <= st_q != ST_RESET;
      if (ir_q == `BSTAP_IR_DISENGAGE)
        cfg_ctrl_idle_o <= 1'b1;
      else if (ir_q == `BSTAP_IR_ENGAGE)
        cfg_ctrl_idle_o <= 1'b0;
      // one low system-clock pulse each time the instruction changes to reconfig
      rcfg_q <= ir_q == `BSTAP_IR_RECONFIG;
      config_request_n_o <= !((ir_q == `BSTAP_IR_RECONFIG) && !rcfg_q);
      bsr_si_o <= tdi;
      bsr_shift_o <= sh_dr && is_bsr;
      bsr_capture_o <= cap_dr && is_bsr;
      bsr_update_o <= tck_rise && st_q == ST_UPD_DR && is_bsr;
      io_config_shift_reg_sel_o <= is_cfgio;
    end
  end

  // tms-high run length, saturating at five, so the reset check needs no long repetition
  logic [2:0] tms_run_q;
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      tms_run_q <= 3'h0;
    else if (tck_rise && !tms)
      tms_run_q <= 3'h0;
    else if (tck_rise && tms_run_q != 3'h5)
      tms_run_q <= tms_run_q + 3'h1;
  end

  AST_IR_RESET: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (tck_rise && st_q == ST_RESET) |=> ir_q == `BSTAP_IR_IDCODE)
    else $error("ir not idcode after reset state");
  AST_TMS_HOLD: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (tck_rise && tms && st_q == ST_RESET) |=> st_q == ST_RESET)
    else $error("left reset with tms high");
  AST_SHIR_STAY: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (tck_rise && !tms && st_q == ST_SH_IR) |=> st_q == ST_SH_IR)
    else $error("left shift-ir with tms low");
  AST_TDO_OE: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    tck_fall |=> tdo_oe_o == $past(in_shift))
    else $error("tdo enable wrong at falling edge");
  AST_TDO_EX1: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (tck_fall && st_q == ST_EX1_IR) |=> !tdo_oe_o)
    else $error("tdo driven in exit1-ir");
  AST_IR_UPD: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (!tck_rise || (st_q != ST_UPD_IR && st_q != ST_RESET)) |=> $stable(ir_q))
    else $error("instruction changed outside update-ir");
  AST_CAP_PAT: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (tck_rise && st_q == ST_CAP_IR) |=> ir_sh_q == `BSTAP_IR_CAPTURE)
    else $error("capture pattern missing");
  AST_BYP: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    sh_dr |=> byp_q == $past(tdi))
    else $error("bypass bit not captured");
  AST_FLOAT: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    hold_feature_i |=> !pins_float_o)
    else $error("float overrode hold feature");
  AST_RST_ST: assert property (@(posedge clk_sys_i)
    srst_i |=> st_q == ST_RESET)
    else $error("controller not in reset after power-up reset");
  AST_FIVE: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    tms_run_q == 3'h5 |-> st_q == ST_RESET)
    else $error("five tms-high edges did not reach reset");
  AST_ST_HOLD: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    !tck_rise |=> $stable(st_q))
    else $error("state moved without a tck rise");
  AST_TDO_IR: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (tck_fall && in_ir) |=> tdo_o == $past(ir_sh_q[0]))
    else $error("tdo not instruction bit in shift-ir");
  AST_IR_SHIFT: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (tck_rise && st_q == ST_SH_IR) |=> ir_sh_q[9] == $past(tdi))
    else $error("tdi not taken into instruction shifter");
  AST_BYP_OUT: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (tck_fall && st_q == ST_SH_DR && dr_sel == DR_BYPASS && !is_cfgio) |=> tdo_o == $past(byp_q))
    else $error("tdo not bypass bit");
  AST_CLAMP: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    pins_clamp_o |-> $past(ir_q) == `BSTAP_IR_CLAMP)
    else $error("clamp without clamp instruction");
  AST_REQ_ONE: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    !config_request_n_o |=> config_request_n_o)
    else $error("config request low longer than one clock");
  AST_IDLE_SET: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    ir_q == `BSTAP_IR_DISENGAGE |=> cfg_ctrl_idle_o)
    else $error("controllers not idled");
  AST_ENGAGE: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    ir_q == `BSTAP_IR_ENGAGE |=> !cfg_ctrl_idle_o)
    else $error("controllers not re-engaged");
  AST_BOOT_LD: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    flash_boot_load_o |-> flash_boot_addr_o == $past(boot_sh_q))
    else $error("boot address not the shifted value");
  AST_BOOT_SH: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (sh_dr && dr_sel == DR_BOOT) |=> boot_sh_q[21] == $past(tdi))
    else $error("tdi not taken into boot address shifter");
  AST_SCAN_ACT: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    st_q == ST_RESET |=> !scan_active_o)
    else $error("scan logic active in reset state");
  AST_IOSEL: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    is_cfgio |=> io_config_shift_reg_sel_o)
    else $error("io shift register not selected");
  AST_ID_SEL: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (cap_dr && is_id) |=> dr32_q == ID_VALUE)
    else $error("identification value not captured");
  AST_USER_SEL: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (cap_dr && is_user) |=> dr32_q == USER_VALUE)
    else $error("user code not captured");
endmodule : bstap_top
`default_nettype wire

// [logic/bstap_map.svh]
// constants for the boundary-scan tap controller
`ifndef BSTAP_MAP_SVH
`define BSTAP_MAP_SVH
`define BSTAP_IR_W 10
`define BSTAP_IR_BYPASS 10'h3FF
`define BSTAP_IR_USERCODE 10'h007
`define BSTAP_IR_IDCODE 10'h006
`define BSTAP_IR_HIGHZ 10'h00B
`define BSTAP_IR_CLAMP 10'h00A
`define BSTAP_IR_RECONFIG 10'h001
`define BSTAP_IR_CONFIG_IO 10'h00D
`define BSTAP_IR_DISENGAGE 10'h2D0
`define BSTAP_IR_ENGAGE 10'h2B0
`define BSTAP_IR_BOOT_ADDR 10'h270
`define BSTAP_IR_SAMPLE 10'h005
`define BSTAP_IR_EXTEST 10'h00F
`define BSTAP_IR_CAPTURE 10'h155
`define BSTAP_ID_W 32
`define BSTAP_BOOT_W 22
`endif

// [logic/bstap_pkg.sv]
// types for the boundary-scan tap controller
`default_nettype none
package bstap_pkg;
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR,
    ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } bstap_state_e;
  typedef enum logic [2:0] {
    DR_BYPASS, DR_IDCODE, DR_USERCODE, DR_BOOT, DR_BSR
  } bstap_dr_e;
endpackage : bstap_pkg
`default_nettype wire

// [verif/bstap_host.sv]
// host model that drives the four-wire test link
`timescale 1ns/1ns
`default_nettype none
module bstap_host (
  // link pins
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  input wire logic tdo_i,
  input wire logic tdo_oe_i
);
  // tck rests low between frames, as a real host leaves it
  initial
  begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end
  // one 125 ns tck pulse; tdo is read just before the rise, after the design's fall update
  task automatic step(input logic tms, input logic tdi, output logic tdo, output logic oe);
    tms_o = tms;
    tdi_o = tdi;
    #62;
    tdo = tdo_i;
    oe = tdo_oe_i;
    tck_o = 1'b1;
    #63;
    tck_o = 1'b0;
  endtask : step
  task automatic to_reset();
    logic t;
    logic e;
    repeat (5) step(1'b1, 1'b0, t, e);
  endtask : to_reset
  // from reset or idle: 0,1,(1),0,0 reaches the shift state, lsb first, exit on last bit
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout, output logic oe_all, output logic oe_after);
    logic t;
    logic e;
    int i;
    step(1'b0, 1'b0, t, e);
    step(1'b1, 1'b0, t, e);
    if (ir)
      step(1'b1, 1'b0, t, e);
    step(1'b0, 1'b0, t, e);
    step(1'b0, 1'b0, t, e);
    oe_all = 1'b1;
    dout = 32'h0;
    for (i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], t, e);
      dout[i] = t;
      oe_all = oe_all & e;
    end
    step(1'b1, 1'b0, t, oe_after);
    step(1'b0, 1'b0, t, e);
  endtask : scan
endmodule : bstap_host
`default_nettype wire

// [verif/tb.sv]
// self-checking bench for the boundary-scan tap controller
`timescale 1ns/1ns
`default_nettype none
`include "bstap_map.svh"
module tb;
  localparam logic [31:0] ID_V = 32'h1234_5679; // arbitrary value
  localparam logic [31:0] USER_V = 32'hA5C3_0F1E;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic hold_i = 1'b0;
  logic tck, tms, tdi, tdo, tdo_oe, float_o, clamp_o, extest_o, active_o;
  logic req_n, idle_o, iosel_o, boot_ld, oa, ob;
  logic bsr_si, bsr_sh, bsr_cap, bsr_upd;
  int n_sh = 0;
  int n_one = 0;
  int n_cap = 0;
  int n_upd = 0;
  logic [21:0] boot_addr;
  logic [31:0] r;
  int n_mismatch = 0;
  int check_count = 0;
  int n_req = 0;
  int n_boot = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  // pulses last one clock, so count them rather than chase them
  always @(posedge clk_sys_i)
  begin
    if (req_n === 1'b0)
      n_req++;
    if (boot_ld === 1'b1)
      n_boot++;
    if (bsr_sh === 1'b1)
      n_sh++;
    if (bsr_sh === 1'b1 && bsr_si === 1'b1)
      n_one++;
    if (bsr_cap === 1'b1)
      n_cap++;
    if (bsr_upd === 1'b1)
      n_upd++;
  end
  bstap_host bstap_host_inst (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo),
    .tdo_oe_i(tdo_oe));
  bstap_top #(.ID_VALUE(ID_V), .USER_VALUE(USER_V)) bstap_top_inst (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .tdo_o(tdo), .tdo_oe_o(tdo_oe), .bsr_so_i(1'b1), .bsr_si_o(bsr_si), .bsr_shift_o(bsr_sh),
    .bsr_capture_o(bsr_cap), .bsr_update_o(bsr_upd), .io_config_shift_reg_so_i(1'b0), .io_config_shift_reg_sel_o(iosel_o),
    .hold_feature_i(hold_i), .pins_float_o(float_o), .pins_clamp_o(clamp_o),
    .pins_extest_o(extest_o), .scan_active_o(active_o), .config_request_n_o(req_n),
    .cfg_ctrl_idle_o(idle_o), .flash_boot_addr_o(boot_addr), .flash_boot_load_o(boot_ld));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic load(input logic [9:0] code);
    bstap_host_inst.scan(1'b1, 10, {22'h0, code}, r, oa, ob);
  endtask : load
  task automatic t_capture();
    bstap_host_inst.scan(1'b1, 10, {22'h0, `BSTAP_IR_BYPASS}, r, oa, ob);
    check("ir capture", r, 32'h155);
    check("tdo on in shift", oa, 1'b1);
    check("tdo off at exit", ob, 1'b0);
    bstap_host_inst.scan(1'b0, 8, 32'hB4, r, oa, ob);
    check("bypass", r, 32'h68);
  endtask : t_capture
  task automatic t_user_id();
    load(`BSTAP_IR_USERCODE);
    bstap_host_inst.scan(1'b0, 32, 32'h0, r, oa, ob);
    check("usercode", r, USER_V);
    bstap_host_inst.to_reset();
    check("scan off in reset", active_o, 1'b0);
    bstap_host_inst.scan(1'b0, 32, 32'h0, r, oa, ob);
    check("idcode", r, ID_V);
  endtask : t_user_id
  task automatic t_pins();
    logic [9:0] codes [5] = '{`BSTAP_IR_HIGHZ, `BSTAP_IR_HIGHZ, `BSTAP_IR_CLAMP, 10'h3A5,
      `BSTAP_IR_EXTEST};
    int i;
    int s0, o0, c0, u0;
    for (i = 0; i < 5; i++)
    begin
      @(negedge clk_sys_i);
      hold_i = (i == 1);
      load(codes[i]);
      check("float", float_o, i == 0);
      check("clamp", clamp_o, i == 2);
      check("extest", extest_o, i == 4);
      s0 = n_sh;
      o0 = n_one;
      c0 = n_cap;
      u0 = n_upd;
      bstap_host_inst.scan(1'b0, 8, 32'hB4, r, oa, ob);
      check("data path", r, (i == 4) ? 32'hFF : 32'h68);
      check("bsr shifts", n_sh - s0, (i == 4) ? 8 : 0);
      check("bsr ones", n_one - o0, (i == 4) ? 4 : 0);
      check("bsr capture", n_cap - c0, i == 4);
      check("bsr update", n_upd - u0, i == 4);
    end
    @(negedge clk_sys_i);
    hold_i = 1'b0;
  endtask : t_pins
  task automatic t_reset();
    @(negedge clk_sys_i);
    srst_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    srst_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    check("mid reset extest off", extest_o, 1'b0);
    check("mid reset scan off", active_o, 1'b0);
    bstap_host_inst.scan(1'b0, 32, 32'h0, r, oa, ob);
    check("idcode after reset", r, ID_V);
  endtask : t_reset
  task automatic t_cfg();
    int q;
    q = n_req;
    load(`BSTAP_IR_RECONFIG);
    check("reconfig pulses", n_req - q, 1);
    load(`BSTAP_IR_DISENGAGE);
    check("ctrl idle", idle_o, 1'b1);
    load(`BSTAP_IR_ENGAGE);
    check("ctrl engaged", idle_o, 1'b0);
    load(`BSTAP_IR_CONFIG_IO);
    check("io select", iosel_o, 1'b1);
    q = n_boot;
    load(`BSTAP_IR_BOOT_ADDR);
    bstap_host_inst.scan(1'b0, 22, 32'h2A5C3D, r, oa, ob);
    check("boot address", boot_addr, 32'h2A5C3D);
    check("boot load", n_boot - q, 1);
  endtask : t_cfg
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results
  // cuts a hung run short
  initial
  begin
    #800000;
    n_mismatch++;
    results();
  end
  initial
  begin
    repeat (3) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    srst_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    check("reset tdo off", tdo_oe, 1'b0);
    check("reset request", req_n, 1'b1);
    check("reset scan off", active_o, 1'b0);
    t_capture();
    t_user_id();
    t_pins();
    t_reset();
    t_cfg();
    results();
  end
endmodule : tb
`default_nettype wire
